//--- hdl/qsd_device.sv
// Switch device end: protection, flags and serial diagnostic readout
// Notes on behaviour
// - Diagnostics form one eleven-bit serial word
// - Select high loads word; low starts shifting
// - Output changes on falling clock; sampled rising
// - Data output released while select is high
// - First bit shown; controller waits 500 ns
// - After eleven bits output holds one
// - First four bits are channel load errors
// - Bits five to eight give commanded states
// - Bit nine low above 145 degrees
// - Bit ten low during thermal shutdown
// - Bit eleven flags overvoltage, drivers off
// - Shutdown at 170 degrees turns all off
// - Switches return after cooling to 160
// - Fault flag low after 75 us persistence
// - Fault flag open drain, needs pull-up
// - Thermal flag low at once on shutdown
// - Pulling thermal flag low forces drivers off
// - Forced shutdown reports like thermal shutdown
// - Thermal flag cannot be held high against internal shutdown
// - Enable low sleeps; 30 us arming delay
// - Overvoltage forces off, releases with hysteresis
// - Load error from output versus threshold
`timescale 1ns/1ps
`default_nettype none
module qsd_device #(
    parameter int ENABLE_DELAY = qsd_pkg::ENABLE_CYCLES,
    parameter int ERR_DELAY = qsd_pkg::ERR_FILTER_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    qsd_if.device link,
    input wire logic enable,
    input wire logic [qsd_pkg::CHANNELS-1:0] chanCmd,
    input wire logic [qsd_pkg::CHANNELS-1:0] outAboveRef,
    input wire logic tempAbove145,
    input wire logic tempAbove170,
    input wire logic tempAbove160,
    input wire logic supplyAbove35,
    input wire logic supplyAboveRelease,
    output logic [qsd_pkg::CHANNELS-1:0] switchOn,
    output logic armed
);
    import qsd_pkg::*;
    localparam int NS = 2 * CHANNELS + 7;
    // Select idles high, so no false frame start after reset
    localparam logic [NS-1:0] SYNC_IDLE = {{(NS-6){1'h0}}, 1'h1, 5'h00};
    localparam int EW = $clog2(ENABLE_DELAY + 1);
    localparam logic [EW-1:0] EN_LAST = EW'(ENABLE_DELAY - 1);

    // ==========================================
    // Input synchronisers
    logic [NS-1:0] syncA_reg;
    logic [NS-1:0] syncB_reg;
    wire [NS-1:0] rawIn = {outAboveRef, chanCmd, enable, link.cs, tempAbove145,
        tempAbove170, tempAbove160, supplyAbove35, supplyAboveRelease};
    wire relS = syncB_reg[0];
    wire ovS = syncB_reg[1];
    wire t160S = syncB_reg[2];
    wire t170S = syncB_reg[3];
    wire t145S = syncB_reg[4];
    wire csS = syncB_reg[5];
    wire enS = syncB_reg[6];
    wire [CHANNELS-1:0] cmdS = syncB_reg[CHANNELS+6:7];
    wire [CHANNELS-1:0] aboveS = syncB_reg[NS-1:CHANNELS+7];

    logic tsdA_reg;
    logic tsdB_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA_reg <= SYNC_IDLE;
            syncB_reg <= SYNC_IDLE;
            tsdA_reg <= 1'b1;
            tsdB_reg <= 1'b1;
        end else begin
            syncA_reg <= rawIn;
            syncB_reg <= syncA_reg;
            tsdA_reg <= link.tsdLevel;
            tsdB_reg <= tsdA_reg;
        end
    end

    // ==========================================
    // Sleep and arming delay
    logic [EW-1:0] armCount_reg;
    logic [EW-1:0] armCount_next;
    logic armed_reg;
    logic armed_next;

    assign armCount_next = !enS ? '0 : (armCount_reg == EN_LAST ? armCount_reg
        : armCount_reg + EW'(1));
    assign armed_next = enS && (armCount_reg == EN_LAST);
    assign armed = armed_reg;

    // ==========================================
    // Thermal and overvoltage protection state
    logic thermShut_reg;
    logic thermShut_next;
    logic overVolt_reg;
    logic overVolt_next;

    assign thermShut_next = !enS ? 1'b0 : (t170S ? 1'b1
        : (t160S ? thermShut_reg : 1'b0));
    assign overVolt_next = !enS ? 1'b0 : (ovS ? 1'b1
        : (relS ? overVolt_reg : 1'b0));

    // Thermal flag pin pulled low by internal shutdown
    assign link.tsdDevOut = 1'b0;
    assign link.tsdDevOe_n = !thermShut_reg;
    // Pin level decides: external or internal low forces off
    wire forcedOff = !tsdB_reg;

    // ==========================================
    // Switch drive
    logic [CHANNELS-1:0] switch_reg;
    logic [CHANNELS-1:0] switch_next;
    wire allOff = !armed_reg || forcedOff || overVolt_reg;
    assign switch_next = allOff ? '0 : cmdS;
    assign switchOn = switch_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armCount_reg <= '0;
            armed_reg <= 1'b0;
            thermShut_reg <= 1'b0;
            overVolt_reg <= 1'b0;
            switch_reg <= '0;
        end else begin
            armCount_reg <= armCount_next;
            armed_reg <= armed_next;
            thermShut_reg <= thermShut_next;
            overVolt_reg <= overVolt_next;
            switch_reg <= switch_next;
        end
    end

    // ==========================================
    // Diagnostic word assembly
    wire [CHANNELS-1:0] loadErr = (cmdS & ~aboveS) | (~cmdS & aboveS);
    wire warnN = !(t145S || forcedOff);
    wire shutN = !forcedOff;
    wire [DIAG_BITS-1:0] liveWord = {overVolt_reg, shutN, warnN, cmdS, loadErr};
    wire anyErr = enS && ((|loadErr) || !warnN || overVolt_reg);

    logic [DIAG_BITS-1:0] word_reg;
    logic [DIAG_BITS-1:0] word_next;
    logic frameTag_reg;
    logic frameTag_next;
    logic csPrev_reg;

    assign word_next = csS ? liveWord : word_reg;
    assign frameTag_next = (csPrev_reg && !csS) ? !frameTag_reg : frameTag_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_reg <= DIAG_RESET;
            frameTag_reg <= 1'b0;
            csPrev_reg <= 1'b1;
        end else begin
            word_reg <= word_next;
            frameTag_reg <= frameTag_next;
            csPrev_reg <= csS;
        end
    end

    // ==========================================
    // Summary fault flag
    logic errFlagged;

    qsd_err_filter #(
        .DELAY_CYCLES(ERR_DELAY)
    ) u_filter (
        .clk(clk),
        .rst_n(rst_n),
        .errIn(anyErr),
        .flagged(errFlagged)
    );

    assign link.errOut = 1'b0;
    assign link.errOe_n = !errFlagged;

    // ==========================================
    // Link clock domain: shift position
    // Word and tag are frozen from just after select falls until it rises
    logic [3:0] bitIdx_reg;
    logic [3:0] bitIdx_next;
    logic seenTag_reg;

    always_comb begin
        bitIdx_next = 4'h1;
        if (seenTag_reg == frameTag_reg) begin
            bitIdx_next = (bitIdx_reg == IDX_DONE) ? IDX_DONE : bitIdx_reg + 4'h1;
        end
    end

    always_ff @(negedge link.sclk) begin
        bitIdx_reg <= bitIdx_next;
        seenTag_reg <= frameTag_reg;
    end

    // ==========================================
    // Serial data output
    logic [3:0] outIdx;

    always_comb begin
        outIdx = 4'h0;
        if (seenTag_reg == frameTag_reg) begin
            outIdx = bitIdx_reg;
        end
    end

    assign link.sdo = (outIdx >= IDX_DONE) ? 1'b1 : word_reg[outIdx];
    assign link.sdoOe_n = link.cs;
endmodule // qsd_device
`default_nettype wire

//--- hdl/qsd_pkg.sv
// Shared constants for the quad switch diagnostic readout
package qsd_pkg;
    // ==========================================
    // Diagnostic word
    localparam int DIAG_BITS = 11;
    localparam int CHANNELS = 4;
    localparam int POS_LOAD_ERR = 0;
    localparam int POS_CMD_STATE = 4;
    localparam int POS_TEMP_WARN_N = 8;
    localparam int POS_THERM_SHUT_N = 9;
    localparam int POS_OVER_VOLT = 10;
    localparam logic [3:0] IDX_DONE = 4'hB;
    localparam logic [DIAG_BITS-1:0] DIAG_RESET = 11'h300;
    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int SETUP_NS = 500;
    localparam int ENABLE_DELAY_NS = 30000;
    localparam int ERR_FILTER_NS = 75000;
    localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ENABLE_CYCLES = (ENABLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERR_FILTER_CYCLES = ERR_FILTER_NS / CLK_PERIOD_NS;
    localparam int HOST_HALF_CYCLES = 4;
    // ==========================================
    // Host sequencer states
    typedef enum logic [2:0] {QSD_IDLE, QSD_SETUP, QSD_HIGH, QSD_LOW, QSD_END} qsd_host_state_e;
endpackage

//--- hdl/qsd_if.sv
// Serial link and flag pins between controller and switch device
`timescale 1ns/1ps
`default_nettype none
interface qsd_if;
    logic cs;
    logic sclk;
    logic sdo;
    logic sdoOe_n;
    logic errOut;
    logic errOe_n;
    logic tsdDevOut;
    logic tsdDevOe_n;
    logic tsdHostOut;
    logic tsdHostOe_n;
    logic sdoLevel;
    logic errLevel;
    logic tsdLevel;

    // ==========================================
    // Wire resolution with pull-ups
    assign sdoLevel = sdoOe_n ? 1'b1 : sdo;
    assign errLevel = errOe_n ? 1'b1 : errOut;
    assign tsdLevel = (!tsdDevOe_n && !tsdDevOut) || (!tsdHostOe_n && !tsdHostOut) ? 1'b0 : 1'b1;

    modport device (
        input cs, sclk, tsdLevel,
        output sdo, sdoOe_n, errOut, errOe_n, tsdDevOut, tsdDevOe_n
    );
    modport host (
        input sdoLevel, errLevel, tsdLevel,
        output cs, sclk, tsdHostOut, tsdHostOe_n
    );
endinterface
`default_nettype wire

//--- hdl/qsd_err_filter.sv
// Persistence filter for the summary fault flag
`timescale 1ns/1ps
`default_nettype none
module qsd_err_filter #(
    parameter int DELAY_CYCLES = qsd_pkg::ERR_FILTER_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic errIn,
    output logic flagged
);
    import qsd_pkg::*;
    localparam int CW = $clog2(DELAY_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(DELAY_CYCLES - 1);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic flag_reg;
    logic flag_next;
    wire reached = (count_reg == LAST);

    // ==========================================
    // Count persistence, restart on clear
    assign count_next = !errIn ? '0 : (reached ? count_reg : count_reg + CW'(1));
    assign flag_next = errIn && reached;
    assign flagged = flag_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
            flag_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            flag_reg <= flag_next;
        end
    end
endmodule // qsd_err_filter
`default_nettype wire

//--- hdl/qsd_host.sv
// Controller end: reads the diagnostic word and watches the flags
`timescale 1ns/1ps
`default_nettype none
module qsd_host #(
    parameter int HALF = qsd_pkg::HOST_HALF_CYCLES,
    parameter int SETUP = qsd_pkg::SETUP_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    qsd_if.host link,
    input wire logic start,
    input wire logic forceShutdown,
    output logic busy,
    output logic done,
    output logic [qsd_pkg::DIAG_BITS-1:0] diagWord,
    output logic faultSeen,
    output logic thermalSeen
);
    import qsd_pkg::*;
    localparam int TW = 8;
    localparam logic [TW-1:0] HALF_LAST = TW'(HALF - 1);
    localparam logic [TW-1:0] SETUP_LAST = TW'(SETUP + 2);

    // ==========================================
    // Pin synchronisers
    logic [2:0] syncA_reg;
    logic [2:0] syncB_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA_reg <= 3'h7;
            syncB_reg <= 3'h7;
        end else begin
            syncA_reg <= {link.tsdLevel, link.errLevel, link.sdoLevel};
            syncB_reg <= syncA_reg;
        end
    end

    assign faultSeen = !syncB_reg[1];
    assign thermalSeen = !syncB_reg[2];
    // External shutdown request
    assign link.tsdHostOut = 1'b0;
    assign link.tsdHostOe_n = !forceShutdown;

    // ==========================================
    // Frame sequencer
    qsd_host_state_e state_reg;
    qsd_host_state_e state_next;
    logic [TW-1:0] timer_reg;
    logic [TW-1:0] timer_next;
    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic [DIAG_BITS-1:0] word_reg;
    logic [DIAG_BITS-1:0] word_next;
    logic done_reg;
    logic done_next;

    wire setupOver = (timer_reg == SETUP_LAST);
    wire halfOver = (timer_reg == HALF_LAST);

    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg + TW'(1);
        count_next = count_reg;
        word_next = word_reg;
        done_next = 1'b0;
        case (state_reg)
            QSD_IDLE: begin
                timer_next = '0;
                count_next = '0;
                if (start) begin
                    state_next = QSD_SETUP;
                end
            end
            QSD_SETUP: begin
                if (setupOver) begin
                    state_next = QSD_HIGH;
                    timer_next = '0;
                    word_next = {syncB_reg[0], word_reg[DIAG_BITS-1:1]};
                end
            end
            QSD_HIGH: begin
                if (halfOver) begin
                    state_next = QSD_LOW;
                    timer_next = '0;
                    count_next = count_reg + 4'h1;
                end
            end
            QSD_LOW: begin
                if (halfOver) begin
                    timer_next = '0;
                    if (count_reg == IDX_DONE) begin
                        state_next = QSD_END;
                    end else begin
                        state_next = QSD_HIGH;
                        word_next = {syncB_reg[0], word_reg[DIAG_BITS-1:1]};
                    end
                end
            end
            QSD_END: begin
                state_next = QSD_IDLE;
                done_next = 1'b1;
            end
            default: begin
                state_next = QSD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= QSD_IDLE;
            timer_reg <= '0;
            count_reg <= '0;
            word_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            count_reg <= count_next;
            word_reg <= word_next;
            done_reg <= done_next;
        end
    end

    assign link.cs = (state_reg == QSD_IDLE) || (state_reg == QSD_END);
    assign link.sclk = (state_reg == QSD_HIGH);
    assign busy = (state_reg != QSD_IDLE);
    assign done = done_reg;
    assign diagWord = word_reg;
endmodule // qsd_host
`default_nettype wire

//--- verif/qsd_link_asserts.sv
// Interface checks for the diagnostic serial link and flag pins
`timescale 1ns/1ps
`default_nettype none
module qsd_link_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs,
    input wire logic sclk,
    input wire logic sdoOe_n,
    input wire logic sdoLevel,
    input wire logic errOut,
    input wire logic errOe_n,
    input wire logic tsdDevOut,
    input wire logic tsdDevOe_n,
    input wire logic tsdLevel
);
    import qsd_pkg::*;
    localparam int SETUP_MIN = SETUP_CYCLES;
    logic sclkQ;
    logic [7:0] lowCnt;
    logic [3:0] riseCnt;
    logic [3:0] fallCnt;
    // ==========================================
    // Frame counters
    always_ff @(posedge clk) begin
        sclkQ <= sclk;
        if (!rst_n || cs) begin
            lowCnt <= 8'h00;
            riseCnt <= 4'h0;
            fallCnt <= 4'h0;
        end else begin
            lowCnt <= lowCnt + 8'h01;
            riseCnt <= riseCnt + {3'h0, sclk && !sclkQ};
            fallCnt <= fallCnt + {3'h0, !sclk && sclkQ};
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sdo_release_a: assert property (sdoOe_n == cs)
        else $error("data output enable does not follow select");
    err_pull_low_a: assert property (!errOe_n |-> !errOut)
        else $error("fault flag driven high");
    tsd_active_low_a: assert property (!tsdDevOe_n |-> !tsdDevOut && !tsdLevel)
        else $error("thermal flag not pulled low");
    sclk_idle_a: assert property (cs |-> !sclk)
        else $error("shift clock high outside frame");
    setup_wait_a: assert property ($rose(sclk) |-> lowCnt + 8'h01 >= SETUP_MIN)
        else $error("first rising clock too soon after select");
    high_phase_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("shift clock high phase wrong length");
    bit_count_a: assert property ($rose(cs) |-> riseCnt == 4'hB)
        else $error("frame did not carry eleven clocks");
    ones_after_a: assert property (!cs && fallCnt == 4'hB |-> ##2 (cs || sdoLevel))
        else $error("data output not high after last bit");
    bit_stable_a: assert property (!cs && sclk && sclkQ |-> $stable(sdoLevel))
        else $error("data changed while clock high");
    cover property ($rose(cs) && riseCnt == 4'hB);
    cover property (!errOe_n);
    cover property (!tsdLevel && tsdDevOe_n);
endmodule // qsd_link_asserts
`default_nettype wire

//--- verif/quad_switch_diag_readout_tb_top.sv
// Testbench joining the controller end and the switch device end
`timescale 1ns/1ps
`default_nettype none
module quad_switch_diag_readout_tb_top;
    import qsd_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic enable = 1'b0;
    logic [3:0] chanCmd = 4'h0;
    logic [3:0] outAboveRef = 4'h0;
    logic tempAbove145 = 1'b0, tempAbove170 = 1'b0, tempAbove160 = 1'b0;
    logic supplyAbove35 = 1'b0, supplyAboveRelease = 1'b0;
    logic start = 1'b0, forceShutdown = 1'b0;
    logic [3:0] switchOn;
    logic armed, busy, done, faultSeen, thermalSeen;
    logic [10:0] diagWord;
    logic [7:0] pat [4] = '{8'h53, 8'hA6, 8'hFF, 8'h00};
    int failures = 0;
    int testsRun = 0;
    int cycles = 0;
    qsd_if link();
    qsd_device #(.ENABLE_DELAY(8), .ERR_DELAY(10)) qsd_device_inst (.clk(clk), .rst_n(rst_n),
        .link(link), .enable(enable), .chanCmd(chanCmd), .outAboveRef(outAboveRef),
        .tempAbove145(tempAbove145), .tempAbove170(tempAbove170), .tempAbove160(tempAbove160),
        .supplyAbove35(supplyAbove35), .supplyAboveRelease(supplyAboveRelease),
        .switchOn(switchOn), .armed(armed));
    qsd_host qsd_host_inst (.clk(clk), .rst_n(rst_n), .link(link), .start(start),
        .forceShutdown(forceShutdown), .busy(busy), .done(done), .diagWord(diagWord),
        .faultSeen(faultSeen), .thermalSeen(thermalSeen));
    qsd_link_asserts qsd_link_asserts_inst (.clk(clk), .rst_n(rst_n), .cs(link.cs),
        .sclk(link.sclk), .sdoOe_n(link.sdoOe_n), .sdoLevel(link.sdoLevel),
        .errOut(link.errOut), .errOe_n(link.errOe_n), .tsdDevOut(link.tsdDevOut),
        .tsdDevOe_n(link.tsdDevOe_n), .tsdLevel(link.tsdLevel));
    // ==========================================
    // Clock and timeout
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            summarize();
        end
    end
    // ==========================================
    // Tasks
    task automatic checkBit(input string name, input logic exp, input logic got);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic checkWord(input string name, input logic [10:0] exp, input logic [10:0] got);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic readWord();
        int i;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        checkBit("busy", 1'b1, busy);
        for (i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
        checkBit("done", 1'b1, done);
        checkBit("busy", 1'b0, busy);
        repeat (6) @(negedge clk);
    endtask
    task automatic checkSw(input logic [3:0] exp);
        checkWord("switchOn", {7'h00, exp}, {7'h00, switchOn});
    endtask
    function automatic logic [10:0] expWord(input logic sd, input logic ov);
        return {ov, ~sd, ~(tempAbove145 | sd), chanCmd, chanCmd ^ outAboveRef};
    endfunction
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        chanCmd = 4'hF;
        repeat (6) @(negedge clk);
        checkBit("armed", 1'b0, armed);
        checkSw(4'h0);
        checkBit("sdoOe_n", 1'b1, link.sdoOe_n);
        enable = 1'b1;
        repeat (5) @(negedge clk);
        checkBit("armed", 1'b0, armed);
        repeat (15) @(negedge clk);
        checkBit("armed", 1'b1, armed);
        checkSw(4'hF);
        for (int k = 0; k < 4; k++) begin
            chanCmd = pat[k][7:4];
            outAboveRef = pat[k][3:0];
            repeat (6) @(negedge clk);
            readWord();
            checkWord("diagWord", expWord(1'b0, 1'b0), diagWord);
            checkSw(chanCmd);
        end
        chanCmd = 4'hF;
        outAboveRef = 4'hF;
        tempAbove145 = 1'b1;
        repeat (6) @(negedge clk);
        readWord();
        checkWord("diagWord", expWord(1'b0, 1'b0), diagWord);
        checkSw(4'hF);
        tempAbove145 = 1'b0;
        repeat (12) @(negedge clk);
        checkBit("faultSeen", 1'b0, faultSeen);
        for (int k = 0; k < 2; k++) begin
            outAboveRef = 4'hE;
            repeat (8) @(negedge clk);
            outAboveRef = 4'hF;
            repeat (2) @(negedge clk);
        end
        repeat (12) @(negedge clk);
        checkBit("faultSeen", 1'b0, faultSeen);
        outAboveRef = 4'hE;
        repeat (5) @(negedge clk);
        checkBit("faultSeen", 1'b0, faultSeen);
        repeat (20) @(negedge clk);
        checkBit("faultSeen", 1'b1, faultSeen);
        outAboveRef = 4'hF;
        tempAbove145 = 1'b1;
        tempAbove170 = 1'b1;
        tempAbove160 = 1'b1;
        repeat (5) @(negedge clk);
        checkBit("tsdLevel", 1'b0, link.tsdLevel);
        repeat (3) @(negedge clk);
        checkSw(4'h0);
        checkBit("thermalSeen", 1'b1, thermalSeen);
        readWord();
        checkWord("diagWord", expWord(1'b1, 1'b0), diagWord);
        tempAbove170 = 1'b0;
        repeat (8) @(negedge clk);
        checkSw(4'h0);
        tempAbove160 = 1'b0;
        tempAbove145 = 1'b0;
        repeat (8) @(negedge clk);
        checkSw(4'hF);
        checkBit("tsdLevel", 1'b1, link.tsdLevel);
        forceShutdown = 1'b1;
        outAboveRef = 4'h0;
        repeat (6) @(negedge clk);
        checkSw(4'h0);
        readWord();
        checkWord("diagWord", expWord(1'b1, 1'b0), diagWord);
        forceShutdown = 1'b0;
        outAboveRef = 4'hF;
        supplyAbove35 = 1'b1;
        supplyAboveRelease = 1'b1;
        repeat (8) @(negedge clk);
        checkSw(4'h0);
        readWord();
        checkWord("diagWord", expWord(1'b0, 1'b1), diagWord);
        supplyAbove35 = 1'b0;
        repeat (8) @(negedge clk);
        checkSw(4'h0);
        supplyAboveRelease = 1'b0;
        repeat (8) @(negedge clk);
        checkSw(4'hF);
        enable = 1'b0;
        repeat (6) @(negedge clk);
        checkSw(4'h0);
        checkBit("armed", 1'b0, armed);
        summarize();
    end
endmodule // quad_switch_diag_readout_tb_top
`default_nettype wire
